// ### halfbridge_spi_pkg.sv
package halfbridge_spi_pkg;

  // ---------------------------------------------------------------
  // frame layout, low byte is sent first
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] FULL_COUNT = 5'h10;

  typedef struct packed {
    logic [7:0] payload;
    logic operation_select_bit;
    logic [4:0] sel;
    logic ext;
    logic fixed_one;
  } frame_t;

  // ---------------------------------------------------------------
  // register selects, value of address bits 6..2
  // ---------------------------------------------------------------
  localparam logic [4:0] SEL_ENABLE_G1 = 5'h00;
  localparam logic [4:0] SEL_ENABLE_G2 = 5'h10;
  localparam logic [4:0] SEL_ENABLE_G3 = 5'h08;
  localparam logic [4:0] SEL_MODE_G1 = 5'h18;
  localparam logic [4:0] SEL_MODE_G2 = 5'h04;
  localparam logic [4:0] SEL_MODE_G3 = 5'h14;
  localparam logic [4:0] SEL_PULSE_FREQ = 5'h0C;
  localparam logic [4:0] SEL_DUTY_CH1 = 5'h1C;
  localparam logic [4:0] SEL_DUTY_CH2 = 5'h02;
  localparam logic [4:0] SEL_DUTY_CH3 = 5'h12;
  localparam logic [4:0] SEL_IDENTITY = 5'h19;
  localparam logic [4:0] SEL_OVP_FAST = 5'h03;
  localparam logic [4:0] SEL_RESERVED_A = 5'h13;
  localparam logic [4:0] SEL_OPENLOAD_DT_SLEW = 5'h07;
  localparam logic [4:0] SEL_RESERVED_B = 5'h17;
  localparam logic [4:0] SEL_GLOBAL_STATUS = 5'h06;
  localparam logic [4:0] SEL_OC_G1 = 5'h16;
  localparam logic [4:0] SEL_OC_G2 = 5'h0E;
  localparam logic [4:0] SEL_OC_G3 = 5'h1E;
  localparam logic [4:0] SEL_OL_G1 = 5'h01;
  localparam logic [4:0] SEL_OL_G2 = 5'h11;
  localparam logic [4:0] SEL_OL_G3 = 5'h09;

  // ---------------------------------------------------------------
  // control storage slots and reset value
  // ---------------------------------------------------------------
  localparam int CTRL_SLOTS = 12;
  localparam int BRIDGES = 12;
  localparam logic [3:0] SLOT_OVP_FAST = 4'hA;
  localparam logic [3:0] SLOT_OPENLOAD_DT_SLEW = 4'hB;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_OVP_FAST = 8'hF0;
  localparam logic [7:0] MASK_OPENLOAD_DT_SLEW = 8'h37;
  localparam logic [7:0] IDENTITY_FIELD_MASK = 8'h0F;

  typedef struct packed {
    logic hit;
    logic [3:0] slot;
  } slot_t;

  // ---------------------------------------------------------------
  // global status bit positions
  // ---------------------------------------------------------------
  localparam int GS_FRAME_ERR = 7;
  localparam int GS_LATCHED = 6;
  localparam int GS_SUPPLY_LOW = 5;
  localparam int GS_SUPPLY_HIGH = 4;
  localparam int GS_POWER_UP = 3;
  localparam int GS_THERMAL_SD = 2;
  localparam int GS_THERMAL_PW = 1;
  localparam logic [7:0] GLOBAL_RESET = 8'h08;

  function automatic slot_t ctrl_slot(input logic [4:0] sel);
    slot_t s;
    s.hit = 1'b1;
    s.slot = 4'h0;
    unique case (sel)
      SEL_ENABLE_G1: s.slot = 4'h0;
      SEL_ENABLE_G2: s.slot = 4'h1;
      SEL_ENABLE_G3: s.slot = 4'h2;
      SEL_MODE_G1: s.slot = 4'h3;
      SEL_MODE_G2: s.slot = 4'h4;
      SEL_MODE_G3: s.slot = 4'h5;
      SEL_PULSE_FREQ: s.slot = 4'h6;
      SEL_DUTY_CH1: s.slot = 4'h7;
      SEL_DUTY_CH2: s.slot = 4'h8;
      SEL_DUTY_CH3: s.slot = 4'h9;
      SEL_OVP_FAST: s.slot = SLOT_OVP_FAST;
      SEL_OPENLOAD_DT_SLEW: s.slot = SLOT_OPENLOAD_DT_SLEW;
      default: s.hit = 1'b0;
    endcase
    return s;
  endfunction : ctrl_slot

  // reserved bits of a slot never store a one
  function automatic logic [7:0] ctrl_mask(input logic [3:0] slot);
    if (slot == SLOT_OVP_FAST) begin
      return MASK_OVP_FAST;
    end else if (slot == SLOT_OPENLOAD_DT_SLEW) begin
      return MASK_OPENLOAD_DT_SLEW;
    end
    return MASK_FULL;
  endfunction : ctrl_mask

endpackage : halfbridge_spi_pkg

// ### halfbridge_spi_register_map.sv
// Overview of operation
// RL1 - control registers are written and read by frame and keep their value.
// RL2 - for a control register, address bit 7 at 0 reads and at 1 writes.
// RL3 - status registers never take written data, only read or clear.
// RL4 - for a status register, address bit 7 at 1 clears and at 0 reads.
// RL5 - the payload sits in frame bits 15 to 8, the address byte below it.
// RL6 - global status bits 7 to 1 carry error, supply and heat flags.
// RL7 - after reset every control register holds all zeros.
// RL8 - a half-bridge with both its enables set is switched fully off.
// RL9 - control bits change only by host writes, never by the device itself.
// RL10 - address bit 0 is one, bit 1 is the extension flag, 6 to 2 select.
`timescale 1ns/1ps
module halfbridge_spi_register_map #(
  // arbitrary value, identifies nothing
  parameter logic [3:0] IDENTITY = 4'h5
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic thermal_shutdown,
  input wire logic thermal_prewarn,
  input wire logic [23:0] overcurrent_hit,
  input wire logic [23:0] openload_hit,
  output logic [11:0] upper_switch_on,
  output logic [11:0] lower_switch_on,
  output logic [95:0] ctrl_image
);

  // ---------------------------------------------------------------
  // link side, runs only while the host clocks a frame
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] shift_q, shift_d;
  logic frame_ok_q, frame_ok_d;
  logic tx_bit_q, tx_bit_d;
  logic [15:0] resp_q, resp_d;

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    if (bit_cnt_q != halfbridge_spi_pkg::FULL_COUNT) begin
      bit_cnt_d = bit_cnt_q + 5'h01;
    end
    shift_d = {serial_in, shift_q[15:1]}; // RL5
    // true only when the last edge seen was exactly the sixteenth
    frame_ok_d = (bit_cnt_q == halfbridge_spi_pkg::LAST_BIT);
    // resp_q only moves after the frame it answers, so it is quiet here
    tx_bit_d = 1'b0;
    if (bit_cnt_q != halfbridge_spi_pkg::FULL_COUNT) begin
      tx_bit_d = resp_q[bit_cnt_q[3:0]];
    end
  end

  // counter restarts with every frame, select high clears it
  always_ff @(posedge link_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // word and verdict survive the frame end for the core to fetch
  always_ff @(posedge link_clk) begin
    shift_q <= shift_d;
    frame_ok_q <= frame_ok_d;
  end

  always_ff @(negedge link_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_bit_q <= 1'b0;
    end else begin
      tx_bit_q <= tx_bit_d;
    end
  end

  // first bit must stand before the first rising edge
  assign serial_out = (bit_cnt_q == 5'h00) ? resp_q[0] : tx_bit_q;
  assign serial_out_en = ~chip_select_n;

  // ---------------------------------------------------------------
  // synchronisers into the core domain
  // ---------------------------------------------------------------
  // a frame with no link edge keeps the old verdict, so hosts must clock
  localparam int SYNC_W = 54;
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync_in;
  logic cs_s, ok_s, low_s, high_s, shut_s, warn_s;
  logic [23:0] oc_s, ol_s;

  assign sync_in = {chip_select_n, frame_ok_q, supply_low, supply_high,
    thermal_shutdown, thermal_prewarn, overcurrent_hit, openload_hit};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_q <= {1'b1, {(SYNC_W-1){1'b0}}};
      sync2_q <= {1'b1, {(SYNC_W-1){1'b0}}};
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  assign {cs_s, ok_s, low_s, high_s, shut_s, warn_s, oc_s, ol_s} = sync2_q;

  // ---------------------------------------------------------------
  // frame handling and registers
  // ---------------------------------------------------------------
  typedef enum logic {FR_IDLE, FR_ACTIVE} frame_state_t;
  frame_state_t state_q, state_d;
  logic [7:0] ctrl_q [halfbridge_spi_pkg::CTRL_SLOTS];
  logic [7:0] ctrl_d [halfbridge_spi_pkg::CTRL_SLOTS];
  logic [7:0] global_q, global_d;
  logic [23:0] oc_q, oc_d, ol_q, ol_d;
  logic [7:0] global_view;
  halfbridge_spi_pkg::frame_t frame_v;
  halfbridge_spi_pkg::slot_t slot_v;

  // shift_q is quiet here: the link clock stopped before select rose
  assign frame_v = halfbridge_spi_pkg::frame_t'(shift_q);
  assign slot_v = halfbridge_spi_pkg::ctrl_slot(frame_v.sel);

  always_comb begin
    global_view = global_q;
    global_view[halfbridge_spi_pkg::GS_LATCHED] = (|oc_q) | (|ol_q); // RL6
    global_view[0] = 1'b0; // RL6
  end

  always_comb begin
    logic apply;
    logic good;
    logic [7:0] rdata;
    apply = 1'b0;
    good = 1'b0;
    rdata = 8'h00;
    state_d = state_q;
    ctrl_d = ctrl_q; // RL1 RL9
    global_d = global_q;
    oc_d = oc_q;
    ol_d = ol_q;
    resp_d = resp_q;
    unique case (state_q)
      FR_IDLE: begin
        if (!cs_s) begin
          state_d = FR_ACTIVE;
        end
      end
      FR_ACTIVE: begin
        if (cs_s) begin
          state_d = FR_IDLE;
          apply = 1'b1;
        end
      end
    endcase
    good = ok_s & frame_v.fixed_one; // RL10
    if (apply && !good) begin
      global_d[halfbridge_spi_pkg::GS_FRAME_ERR] = 1'b1;
    end
    if (apply && good) begin
      if (slot_v.hit) begin
        rdata = ctrl_q[slot_v.slot]; // RL1
        if (frame_v.operation_select_bit) begin
          ctrl_d[slot_v.slot] = frame_v.payload &
            halfbridge_spi_pkg::ctrl_mask(slot_v.slot); // RL2
        end
      end else begin
        // status selects only read or clear, never store payload
        unique case (frame_v.sel) // RL3
          halfbridge_spi_pkg::SEL_IDENTITY: begin
            rdata = {4'h0, IDENTITY} &
              halfbridge_spi_pkg::IDENTITY_FIELD_MASK;
          end
          halfbridge_spi_pkg::SEL_GLOBAL_STATUS: begin
            rdata = global_view;
            if (frame_v.operation_select_bit) begin
              global_d = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OC_G1: begin
            rdata = oc_q[7:0];
            if (frame_v.operation_select_bit) begin
              oc_d[7:0] = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OC_G2: begin
            rdata = oc_q[15:8];
            if (frame_v.operation_select_bit) begin
              oc_d[15:8] = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OC_G3: begin
            rdata = oc_q[23:16];
            if (frame_v.operation_select_bit) begin
              oc_d[23:16] = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OL_G1: begin
            rdata = ol_q[7:0];
            if (frame_v.operation_select_bit) begin
              ol_d[7:0] = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OL_G2: begin
            rdata = ol_q[15:8];
            if (frame_v.operation_select_bit) begin
              ol_d[15:8] = 8'h00; // RL4
            end
          end
          halfbridge_spi_pkg::SEL_OL_G3: begin
            rdata = ol_q[23:16];
            if (frame_v.operation_select_bit) begin
              ol_d[23:16] = 8'h00; // RL4
            end
          end
          default: rdata = 8'h00;
        endcase
      end
      resp_d = {rdata, global_view}; // RL5 RL6
    end
    // events land after the clear so a set in the clear cycle wins
    global_d[halfbridge_spi_pkg::GS_SUPPLY_LOW] =
      global_d[halfbridge_spi_pkg::GS_SUPPLY_LOW] | low_s;
    global_d[halfbridge_spi_pkg::GS_SUPPLY_HIGH] =
      global_d[halfbridge_spi_pkg::GS_SUPPLY_HIGH] | high_s;
    global_d[halfbridge_spi_pkg::GS_THERMAL_SD] =
      global_d[halfbridge_spi_pkg::GS_THERMAL_SD] | shut_s;
    global_d[halfbridge_spi_pkg::GS_THERMAL_PW] =
      global_d[halfbridge_spi_pkg::GS_THERMAL_PW] | warn_s;
    global_d[halfbridge_spi_pkg::GS_LATCHED] = 1'b0;
    global_d[0] = 1'b0;
    oc_d = oc_d | oc_s;
    ol_d = ol_d | ol_s;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= FR_IDLE;
      for (int i = 0; i < halfbridge_spi_pkg::CTRL_SLOTS; i++) begin
        ctrl_q[i] <= halfbridge_spi_pkg::CTRL_RESET; // RL7
      end
      global_q <= halfbridge_spi_pkg::GLOBAL_RESET;
      oc_q <= 24'h000000;
      ol_q <= 24'h000000;
      resp_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      global_q <= global_d;
      oc_q <= oc_d;
      ol_q <= ol_d;
      resp_q <= resp_d;
    end
  end

  // ---------------------------------------------------------------
  // bridge drive with cross-current lockout
  // ---------------------------------------------------------------
  logic [11:0] upper_d, lower_d;

  for (genvar b = 0; b < halfbridge_spi_pkg::BRIDGES; b++) begin : g_bridge
    logic hi_en, lo_en;
    assign hi_en = ctrl_q[b / 4][2 * (b % 4) + 1];
    assign lo_en = ctrl_q[b / 4][2 * (b % 4)];
    assign upper_d[b] = hi_en & ~lo_en; // RL8
    assign lower_d[b] = lo_en & ~hi_en; // RL8
  end

  for (genvar s = 0; s < halfbridge_spi_pkg::CTRL_SLOTS; s++) begin : g_image
    assign ctrl_image[8 * s +: 8] = ctrl_q[s];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      upper_switch_on <= 12'h000;
      lower_switch_on <= 12'h000;
    end else begin
      upper_switch_on <= upper_d;
      lower_switch_on <= lower_d;
    end
  end

  // ---------------------------------------------------------------
  // elaboration checks on the shared layout
  // ---------------------------------------------------------------
  // the shift word is cast straight onto the frame layout
  if ($bits(halfbridge_spi_pkg::frame_t) !=
      halfbridge_spi_pkg::FRAME_BITS) begin : g_bad_frame
    $error("frame layout and frame length disagree");
  end
  // four bridges share one enable slot, three slots in all
  if (halfbridge_spi_pkg::BRIDGES != 12) begin : g_bad_bridges
    $error("bridge count must fill the three enable slots");
  end
  // the control image is a fixed 96-bit port
  if (halfbridge_spi_pkg::CTRL_SLOTS * 8 != 96) begin : g_bad_slots
    $error("control slots must fill the control image");
  end

endmodule : halfbridge_spi_register_map

// ### spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  // ----------------------------------------
  // frame master, clock idles low
  // ----------------------------------------
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic xfer(input logic [15:0] f, input int n,
      output logic [15:0] r);
    r = 16'h0000;
    chip_select_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      serial_in = f[i];
      #24;
      // taken just ahead of the rise, while the bit still stands
      r[i] = serial_out;
      link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    #24 chip_select_n = 1'b1;
    // released line shows no stale bit
    serial_in = ~serial_in;
    #500;
  endtask : xfer
endmodule : spi_host_model

// ### halfbridge_spi_register_map_assertions.sv
`timescale 1ns/1ps
module hb_spi_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic serial_out_en,
  input wire logic [11:0] upper_switch_on,
  input wire logic [11:0] lower_switch_on,
  input wire logic [95:0] ctrl_image
);
  logic [11:0] up_x;
  logic [11:0] lo_x;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  always_comb begin
    for (int b = 0; b < 12; b++) begin
      up_x[b] = ctrl_image[2*b+1] & ~ctrl_image[2*b];
      lo_x[b] = ctrl_image[2*b] & ~ctrl_image[2*b+1];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_reset_zero;
    $rose(reset_n) |-> ctrl_image == 96'h0 &&
      (upper_switch_on | lower_switch_on) == 12'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero");
  property p_no_cross;
    (upper_switch_on & lower_switch_on) == 12'h0;
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("both on");
  property p_drive;
    1'b1 |=> upper_switch_on == $past(up_x) && lower_switch_on == $past(lo_x);
  endproperty
  a_drive: assert property (p_drive) else $error("drive wrong");
  // a write lands only after the frame has closed
  property p_only_idle;
    !$stable(ctrl_image) |-> chip_select_n && $past(chip_select_n);
  endproperty
  a_only_idle: assert property (p_only_idle) else $error("early write");
  property p_hold_frame;
    !chip_select_n |=> $stable(ctrl_image);
  endproperty
  a_hold_frame: assert property (p_hold_frame) else $error("changed");
  property p_once;
    !$stable(ctrl_image) |=> $stable(ctrl_image) [*6];
  endproperty
  a_once: assert property (p_once) else $error("two updates");
  property p_rsvd_zero;
    ctrl_image[83:80] == 4'h0 && ctrl_image[95:94] == 2'h0 && !ctrl_image[91];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("rsvd set");
  property p_oe;
    serial_out_en == !chip_select_n;
  endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  c_write: cover property (!$stable(ctrl_image));
  c_cross: cover property (ctrl_image[1:0] == 2'h3);
  c_frame: cover property ($fell(chip_select_n));
endmodule : hb_spi_checker

bind halfbridge_spi_register_map hb_spi_checker chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .chip_select_n(chip_select_n),
  .serial_out_en(serial_out_en),
  .upper_switch_on(upper_switch_on),
  .lower_switch_on(lower_switch_on),
  .ctrl_image(ctrl_image)
);

// ### tb_halfbridge_spi_register_map.sv
`timescale 1ns/1ps
module tb_halfbridge_spi_register_map;
  // arbitrary value, identifies nothing
  localparam logic [3:0] IDENT = 4'hA;
  logic core_clk, reset_n, link_clk, chip_select_n, serial_in;
  logic serial_out, serial_out_en;
  logic [3:0] flt;
  logic [23:0] oc_hit, ol_hit;
  logic [11:0] upper_switch_on, lower_switch_on;
  logic [95:0] ctrl_image, img;
  logic [15:0] r;
  logic [7:0] v;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [4:0] sels [12] = '{5'h00, 5'h10, 5'h08, 5'h18, 5'h04, 5'h14,
    5'h0C, 5'h1C, 5'h02, 5'h12, 5'h03, 5'h07};

  halfbridge_spi_register_map #(.IDENTITY(IDENT)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .supply_low(flt[3]), .supply_high(flt[2]),
    .thermal_shutdown(flt[1]), .thermal_prewarn(flt[0]),
    .overcurrent_hit(oc_hit), .openload_hit(ol_hit),
    .upper_switch_on(upper_switch_on), .lower_switch_on(lower_switch_on),
    .ctrl_image(ctrl_image)
  );
  spi_host_model host (.link_clk(link_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // a frame is about 26 cycles, the run about 70 frames
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [4:0] sel,
      input logic [7:0] d);
    host.xfer({d, wr, sel, 2'b01}, 16, r);
  endtask : acc
  // the answer arrives one frame late
  task automatic rd(input logic [4:0] sel);
    acc(1'b0, sel, 8'h00);
    acc(1'b0, halfbridge_spi_pkg::SEL_GLOBAL_STATUS, 8'h00);
    v = r[15:8];
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(ctrl_image, 96'h0);
    chk({upper_switch_on, lower_switch_on}, 24'h0);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h08);
    acc(1'b1, halfbridge_spi_pkg::SEL_GLOBAL_STATUS, 8'hFF);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h00);
  endtask : t_reset
  task automatic t_rw();
    for (int i = 0; i < 12; i++) begin
      acc(1'b1, sels[i], 8'(8'h11 * (i + 1)));
      img[8*i +: 8] = 8'(8'h11 * (i + 1));
    end
    img[83:80] = 4'h0;
    img[95:94] = 2'h0;
    img[91] = 1'b0;
    chk(ctrl_image, img);
    for (int i = 0; i < 12; i++) begin
      rd(sels[i]);
      chk(v, img[8*i +: 8]);
    end
  endtask : t_rw
  task automatic t_bridge();
    acc(1'b1, halfbridge_spi_pkg::SEL_ENABLE_G1, 8'h07);
    img[7:0] = 8'h07;
    chk(upper_switch_on[3:0], 4'h0);
    chk(lower_switch_on[3:0], 4'h2);
  endtask : t_bridge
  task automatic t_status();
    @(posedge core_clk);
    flt <= 4'hF;
    oc_hit <= 24'h000005;
    ol_hit <= 24'h800000;
    repeat (5) @(posedge core_clk);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h76);
    chk(r[7:0], 8'h76);
    @(posedge core_clk);
    flt <= 4'h0;
    oc_hit <= 24'h0;
    ol_hit <= 24'h0;
    for (int k = 0; k < 2; k++) begin
      rd(halfbridge_spi_pkg::SEL_OC_G1);
      chk(v, 8'h05);
    end
    acc(1'b1, halfbridge_spi_pkg::SEL_OC_G1, 8'hFF);
    rd(halfbridge_spi_pkg::SEL_OC_G1);
    chk(v, 8'h00);
    rd(halfbridge_spi_pkg::SEL_OL_G3);
    chk(v, 8'h80);
    acc(1'b1, halfbridge_spi_pkg::SEL_OL_G3, 8'h00);
    acc(1'b1, halfbridge_spi_pkg::SEL_GLOBAL_STATUS, 8'h00);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h00);
    chk(ctrl_image, img);
  endtask : t_status
  task automatic t_error();
    host.xfer({8'h33, 1'b1, halfbridge_spi_pkg::SEL_ENABLE_G2, 2'b00}, 16, r);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h80);
    chk(ctrl_image, img);
    acc(1'b1, halfbridge_spi_pkg::SEL_GLOBAL_STATUS, 8'h00);
    // a frame of eight bits is refused
    host.xfer(16'h33C1, 8, r);
    rd(halfbridge_spi_pkg::SEL_GLOBAL_STATUS);
    chk(v, 8'h80);
    chk(ctrl_image, img);
    acc(1'b1, halfbridge_spi_pkg::SEL_GLOBAL_STATUS, 8'h00);
    // extension flag set still reaches the register
    host.xfer({8'h5A, 1'b1, halfbridge_spi_pkg::SEL_ENABLE_G2, 2'b11}, 16, r);
    img[15:8] = 8'h5A;
    chk(ctrl_image, img);
    acc(1'b1, halfbridge_spi_pkg::SEL_RESERVED_A, 8'hFF);
    acc(1'b1, halfbridge_spi_pkg::SEL_IDENTITY, 8'hFF);
    chk(ctrl_image, img);
    rd(halfbridge_spi_pkg::SEL_RESERVED_A);
    chk(v, 8'h00);
    rd(halfbridge_spi_pkg::SEL_IDENTITY);
    chk(v, {4'h0, IDENT});
  endtask : t_error

  initial begin
    reset_n = 1'b0;
    flt = 4'h0;
    oc_hit = 24'h0;
    ol_hit = 24'h0;
    img = 96'h0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_rw();
    t_bridge();
    t_status();
    t_error();
    test_done();
  end
endmodule : tb_halfbridge_spi_register_map
